// [src/sleep_map.svh]
// Purpose : register offsets, field positions, reset values and timing counts
// Assumes : 32-bit AXI4-Lite data, one aligned word per register
// Notes   : definitions only
`ifndef SLEEP_MAP_SVH
`define SLEEP_MAP_SVH

// register byte offsets
`define OFS_CORE_CTRL     8'h00
`define OFS_COMP_CTRL     8'h04
`define OFS_WAKE_CFG      8'h08
`define OFS_SLEEP_STATUS  8'h0c

// core_control_register fields
`define BIT_SLEEP_ENABLE  5
`define BIT_SLEEP_KIND    4
`define CORE_CTRL_MASK    8'h3f
`define CORE_CTRL_RESET   8'h00
// sense control of the two external interrupts: 2'b00 means low level
`define ISC0_LSB          0
`define ISC1_LSB          2
`define SENSE_LOW_LEVEL   2'b00

// comparator_ctrl_status fields
`define BIT_COMP_DISABLE  7
`define COMP_CTRL_RESET   8'h00

// wake configuration: clock_source_fuses in bits 1:0
`define FUSE_LSB          0
`define FUSE_RESET        2'h0

// status fields
`define STAT_STATE_LSB    0
`define BIT_STAT_SKIP     4
`define BIT_STAT_RSTWAKE  5

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

// timing
`define MCLK_PERIOD_NS    50
`define WDOSC_PERIOD_NS   2700
`define WDOSC_CYC         (`WDOSC_PERIOD_NS / `MCLK_PERIOD_NS)
`define WDOSC_TWO_CYC     (2 * `WDOSC_CYC)
`define WD_QUAL_EDGES     2'd2

`endif

// [src/sleep_pkg.sv]
// Purpose : shared types of the sleep controller
// Assumes : nothing
// Notes   : states are one-hot
package sleep_pkg;

  typedef enum logic [3:0] {
    ST_ACTIVE  = 4'b0001,
    ST_IDLE    = 4'b0010,
    ST_PDOWN   = 4'b0100,
    ST_STARTUP = 4'b1000
  } sleep_state_t;

  typedef logic [15:0] cycle_count_t;
  typedef logic [1:0]  fuse_sel_t;

endpackage

// [src/wake_if.sv]
// Purpose : carrier between the controller, the level qualifier and the start-up timer
// Assumes : all on MCLK
// Notes   : none
`timescale 1ns/100ps
interface wake_if;
  import sleep_pkg::*;

  logic         arm;
  logic         level;
  logic         wd_tick;
  cycle_count_t wake_cycles;
  logic         qualified;
  logic         start;
  logic         done;

  modport ctl  (output arm, output level, output wd_tick, output wake_cycles,
                output start, input qualified, input done);
  modport qual (input arm, input level, input wd_tick, input wake_cycles,
                output qualified);
  modport tmr  (input start, input wake_cycles, output done);
endinterface

// [src/level_qualifier.sv]
// Purpose : qualifies a wake level held during power-down
// Assumes : level and wd_tick already synchronised
// Notes   : count restarts whenever the level drops
`timescale 1ns/100ps
`include "sleep_map.svh"
module level_qualifier (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic NRST,
  // link to controller
  wake_if.qual      wk
);
  import sleep_pkg::*;

  logic [1:0]   wd_edges;
  cycle_count_t held;
  logic         short_wake;

  // wake period below two watchdog periods: the wake period is enough
  assign short_wake = (wk.wake_cycles < 16'(`WDOSC_TWO_CYC));

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      wd_edges <= 2'd0;
      held     <= 16'h0000;
    end else if (!wk.arm || !wk.level) begin
      wd_edges <= 2'd0;
      held     <= 16'h0000;
    end else begin
      if (wk.wd_tick && wd_edges != `WD_QUAL_EDGES)
        wd_edges <= wd_edges + 2'd1;
      if (held != 16'hffff)
        held <= held + 16'h0001;
    end
  end

  assign wk.qualified = wk.arm && wk.level &&
                        ((wd_edges == `WD_QUAL_EDGES) ||
                         (short_wake && held >= wk.wake_cycles)); // R10
endmodule

// [src/startup_timer.sv]
// Purpose : counts the oscillator start-up delay after a power-down wake
// Assumes : start is a one-cycle pulse
// Notes   : done pulses once when the count runs out
`timescale 1ns/100ps
module startup_timer (
  // clock and reset
  input  wire logic MCLK,
  input  wire logic NRST,
  // link to controller
  wake_if.tmr       wk
);
  import sleep_pkg::*;

  cycle_count_t remain;
  logic         running;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      remain  <= 16'h0000;
      running <= 1'b0;
    end else if (wk.start) begin
      remain  <= (wk.wake_cycles > 16'h0001) ? wk.wake_cycles - 16'h0001 : 16'h0000;
      running <= 1'b1;
    end else if (running) begin
      if (remain == 16'h0000)
        running <= 1'b0;
      else
        remain <= remain - 16'h0001;
    end
  end

  assign wk.done = running && (remain == 16'h0000);
endmodule

// [src/sleep_mode_controller.sv]
// Purpose : idle and power-down sleep control with wake-up handling
// Assumes : SLEEP_EXEC, IRQ_REQ, COMP_IRQ, WDT_* come from logic on MCLK
// Notes   : pins EXT_INT_N, EXT_RESET_N, WDOSC pass two flip-flops first
//
// Overview of operation
// R01: sleep instruction enters sleep only while sleep-enable is one.
// R02: sleep-kind zero selects idle, one selects power-down.
// R03: enabled interrupt wakes either sleep; handler runs, then code after sleep.
// R04: sleep entry and exit leave all registers unchanged.
// R05: any reset during sleep wakes to the reset vector.
// R06: idle halts only the core; timers, watchdog, interrupts keep running.
// R07: comparator-disable powers comparator down; its interrupt cannot wake.
// R08: power-down stops the oscillator; external interrupts and watchdog keep going.
// R09: power-down wakes on external reset, enabled watchdog reset, level interrupt.
// R10: level qualifies after two watchdog cycles, or the shorter wake period.
// R11: level gone before wake period ends: wake but skip the handler.
// R12: power-down wake waits the fuse-selected clock-counting start-up period.
// R13: watchdog oscillator nominal period is 2.7 us.
// R14: waking level must be held longer than the reset time-out.
// R15: sleep-enable bit 5, sleep-kind bit 4, read/write, cleared at reset.
// R16: software should set sleep-enable just before the sleep instruction.
// R17: idle wake resumes at once, without start-up delay.
`timescale 1ns/100ps
`include "sleep_map.svh"
module sleep_mode_controller #(
  parameter sleep_pkg::cycle_count_t STARTUP_CNT0 = 16'd16,
  parameter sleep_pkg::cycle_count_t STARTUP_CNT1 = 16'd1024,
  parameter sleep_pkg::cycle_count_t STARTUP_CNT2 = 16'd4096,
  parameter sleep_pkg::cycle_count_t STARTUP_CNT3 = 16'd16384
) (
  // clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   NRST,
  // AXI4-Lite write address and data
  input  wire logic [7:0]             S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output      logic                   S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output      logic                   S_AXI_WREADY,
  // AXI4-Lite write response
  output      logic [1:0]             S_AXI_BRESP,
  output      logic                   S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]             S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output      logic                   S_AXI_ARREADY,
  output      logic [31:0]            S_AXI_RDATA,
  output      logic [1:0]             S_AXI_RRESP,
  output      logic                   S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  // core side
  input  wire logic                   SLEEP_EXEC,
  output      logic                   CORE_HALT,
  output      logic                   RESUME,
  output      logic                   HANDLER_SKIP,
  output      logic                   RESET_WAKE,
  // interrupt and watchdog side
  input  wire logic                   IRQ_REQ,
  input  wire logic                   COMP_IRQ,
  input  wire logic [1:0]             INT_ENABLE,
  input  wire logic                   WDT_ENABLE,
  input  wire logic                   WDT_RESET,
  // pins
  input  wire logic [1:0]             EXT_INT_N,
  input  wire logic                   EXT_RESET_N,
  input  wire logic                   WDOSC,
  // power control
  output      logic                   OSC_STOP,
  output      logic                   COMP_POWER_DOWN,
  output      sleep_pkg::sleep_state_t STATE
);
  import sleep_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0]   core_ctrl;
  logic [7:0]   comp_ctrl;
  fuse_sel_t    fuse_sel;
  sleep_state_t state;
  sleep_state_t next_state;
  logic         skip_last;
  logic         rst_wake_last;
  logic         rst_pending;
  logic         level_lost;

  wake_if wk ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic cycle_count_t startup_cycles(input fuse_sel_t sel);
    case (sel)
      2'd0:    startup_cycles = STARTUP_CNT0;
      2'd1:    startup_cycles = STARTUP_CNT1;
      2'd2:    startup_cycles = STARTUP_CNT2;
      default: startup_cycles = STARTUP_CNT3;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr[7:2] == ofs[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] int_meta;
  logic [1:0] int_sync;
  logic       rst_meta;
  logic       rst_sync;
  logic       wd_meta;
  logic       wd_sync;
  logic       wd_prev;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      int_meta <= 2'b11;
      int_sync <= 2'b11;
      rst_meta <= 1'b1;
      rst_sync <= 1'b1;
      wd_meta  <= 1'b0;
      wd_sync  <= 1'b0;
      wd_prev  <= 1'b0;
    end else begin
      int_meta <= EXT_INT_N;
      int_sync <= int_meta;
      rst_meta <= EXT_RESET_N;
      rst_sync <= rst_meta;
      wd_meta  <= WDOSC;
      wd_sync  <= wd_meta;
      wd_prev  <= wd_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake sources

  logic level_req;
  logic idle_wake;
  logic pd_reset;
  logic any_reset;

  // of the interrupts, only low-level sensed, enabled external interrupts wake power-down
  assign level_req =
    (INT_ENABLE[0] && !int_sync[0] &&
     core_ctrl[`ISC0_LSB +: 2] == `SENSE_LOW_LEVEL) ||
    (INT_ENABLE[1] && !int_sync[1] &&
     core_ctrl[`ISC1_LSB +: 2] == `SENSE_LOW_LEVEL); // R09

  // comparator request is blocked while the comparator is powered down
  assign idle_wake = IRQ_REQ ||
                     (COMP_IRQ && !comp_ctrl[`BIT_COMP_DISABLE]); // R07 R06 R03
  assign any_reset = !rst_sync || WDT_RESET; // R06 R05
  assign pd_reset  = !rst_sync || (WDT_RESET && WDT_ENABLE); // R09 R08

  assign wk.arm         = (state == ST_PDOWN);
  assign wk.level       = level_req;
  assign wk.wd_tick     = wd_sync && !wd_prev; // R13
  assign wk.wake_cycles = startup_cycles(fuse_sel); // R12
  assign wk.start       = (state == ST_PDOWN) && (pd_reset || wk.qualified);

  level_qualifier u_qual (
    .MCLK (MCLK),
    .NRST (NRST),
    .wk   (wk.qual)
  );

  startup_timer u_timer (
    .MCLK (MCLK),
    .NRST (NRST),
    .wk   (wk.tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sleep state machine

  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (SLEEP_EXEC && core_ctrl[`BIT_SLEEP_ENABLE]) begin // R01 R16
          if (core_ctrl[`BIT_SLEEP_KIND])
            next_state = ST_PDOWN; // R02
          else
            next_state = ST_IDLE; // R02
        end
      end
      ST_IDLE: begin
        if (any_reset || idle_wake)
          next_state = ST_ACTIVE; // R17
      end
      ST_PDOWN: begin
        // a level qualifies after two watchdog edges, or after a wake period shorter than two watchdog periods
        if (wk.start)
          next_state = ST_STARTUP; // R14
      end
      ST_STARTUP: begin
        if (wk.done)
          next_state = ST_ACTIVE; // R12
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // reset cause and level presence during the start-up wait
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_pending <= 1'b0;
      level_lost  <= 1'b0;
    end else if (wk.start) begin
      rst_pending <= pd_reset;
      level_lost  <= !pd_reset && !level_req;
    end else if (state == ST_STARTUP) begin
      if (pd_reset)
        rst_pending <= 1'b1;
      if (!level_req)
        level_lost <= 1'b1; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core side outputs

  logic leave_idle;
  logic leave_start;

  assign leave_idle  = (state == ST_IDLE) && (any_reset || idle_wake);
  assign leave_start = (state == ST_STARTUP) && wk.done;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CORE_HALT       <= 1'b0;
      OSC_STOP        <= 1'b0;
      COMP_POWER_DOWN <= 1'b0;
      RESUME          <= 1'b0;
      HANDLER_SKIP    <= 1'b0;
      RESET_WAKE      <= 1'b0;
      STATE           <= ST_ACTIVE;
    end else begin
      CORE_HALT       <= (next_state != ST_ACTIVE); // R06
      OSC_STOP        <= (next_state == ST_PDOWN); // R08
      COMP_POWER_DOWN <= comp_ctrl[`BIT_COMP_DISABLE]; // R07
      STATE           <= next_state;
      // resume after sleep keeps all core state, the core just continues
      RESUME          <= (leave_idle && !any_reset) ||
                         (leave_start && !rst_pending && !pd_reset); // R03 R04
      HANDLER_SKIP    <= leave_start && !rst_pending && !pd_reset &&
                         (level_lost || !level_req); // R11
      RESET_WAKE      <= (leave_idle && any_reset) ||
                         (leave_start && (rst_pending || pd_reset)); // R05
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      skip_last     <= 1'b0;
      rst_wake_last <= 1'b0;
    end else if (leave_start || leave_idle) begin
      skip_last     <= leave_start && !rst_pending && !pd_reset &&
                       (level_lost || !level_req);
      rst_wake_last <= leave_idle ? any_reset : (rst_pending || pd_reset);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        do_write;

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign do_write      = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held  <= 1'b1;
        w_data  <= S_AXI_WDATA;
        w_lane0 <= S_AXI_WSTRB[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (reg_hit(aw_addr, `OFS_CORE_CTRL) || reg_hit(aw_addr, `OFS_COMP_CTRL) ||
          reg_hit(aw_addr, `OFS_WAKE_CFG) || reg_hit(aw_addr, `OFS_SLEEP_STATUS))
        S_AXI_BRESP <= `RESP_OKAY;
      else
        S_AXI_BRESP <= `RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // control registers; sleeping never touches them
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      core_ctrl <= `CORE_CTRL_RESET; // R15
      comp_ctrl <= `COMP_CTRL_RESET;
      fuse_sel  <= `FUSE_RESET;
    end else if (do_write && w_lane0) begin
      if (reg_hit(aw_addr, `OFS_CORE_CTRL))
        core_ctrl <= w_data[7:0] & `CORE_CTRL_MASK; // R15 R04
      if (reg_hit(aw_addr, `OFS_COMP_CTRL))
        comp_ctrl <= {w_data[`BIT_COMP_DISABLE], 7'h00}; // R07
      if (reg_hit(aw_addr, `OFS_WAKE_CFG))
        fuse_sel <= w_data[`FUSE_LSB +: 2]; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [31:0] rd_word;
  logic        rd_ok;

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (reg_hit(S_AXI_ARADDR, `OFS_CORE_CTRL))
      rd_word[7:0] = core_ctrl; // R15
    else if (reg_hit(S_AXI_ARADDR, `OFS_COMP_CTRL))
      rd_word[7:0] = comp_ctrl;
    else if (reg_hit(S_AXI_ARADDR, `OFS_WAKE_CFG))
      rd_word[`FUSE_LSB +: 2] = fuse_sel;
    else if (reg_hit(S_AXI_ARADDR, `OFS_SLEEP_STATUS)) begin
      rd_word[`STAT_STATE_LSB +: 4] = state;
      rd_word[`BIT_STAT_SKIP]       = skip_last;
      rd_word[`BIT_STAT_RSTWAKE]    = rst_wake_last;
    end else
      rd_ok = 1'b0;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// [verification/sleep_chk.sv]
// Purpose: port-level checks of the sleep controller
// Assumes: one clock, NRST asynchronous and active low
// Notes:   bound to every controller instance
`timescale 1ns/100ps
module sleep_chk (
  // clock and reset
  input wire logic                    MCLK,
  input wire logic                    NRST,
  // core side
  input wire logic                    SLEEP_EXEC,
  input wire logic                    CORE_HALT,
  input wire logic                    RESUME,
  input wire logic                    HANDLER_SKIP,
  input wire logic                    RESET_WAKE,
  // wake sources
  input wire logic                    IRQ_REQ,
  input wire logic                    COMP_IRQ,
  input wire logic                    WDT_RESET,
  input wire logic [1:0]              EXT_INT_N,
  input wire logic                    EXT_RESET_N,
  // power control
  input wire logic                    OSC_STOP,
  input wire logic                    COMP_POWER_DOWN,
  input wire sleep_pkg::sleep_state_t STATE
);
  import sleep_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  logic quiet;
  assign quiet = !WDT_RESET && EXT_RESET_N;
  ////////////////////////////////////////////////////////////////
  chk_halt_level: assert property (CORE_HALT == (STATE != ST_ACTIVE))
    else $error("halt level differs from state");
  chk_osc_stop: assert property (OSC_STOP == (STATE == ST_PDOWN))
    else $error("oscillator stop differs from power-down");
  chk_sleep_cause: assert property
    (STATE != ST_ACTIVE && $past(STATE) == ST_ACTIVE |-> $past(SLEEP_EXEC))
    else $error("sleep entered without sleep instruction");
  chk_idle_wake: assert property
    (STATE == ST_IDLE && IRQ_REQ && quiet |=> RESUME && STATE == ST_ACTIVE)
    else $error("idle did not resume on interrupt");
  chk_idle_exit: assert property
    (STATE == ST_IDLE |=> STATE inside {ST_IDLE, ST_ACTIVE})
    else $error("idle wake went through start-up");
  chk_comp_off: assert property
    (STATE == ST_IDLE && COMP_POWER_DOWN && COMP_IRQ && !IRQ_REQ && quiet
     |=> STATE == ST_IDLE)
    else $error("disabled comparator woke idle");
  chk_pd_edges_off: assert property
    ((STATE == ST_PDOWN && EXT_INT_N == 2'b11 && quiet)[*5] |=> STATE == ST_PDOWN)
    else $error("power-down left without a wake source");
  chk_pd_to_wait: assert property
    (STATE == ST_PDOWN |=> STATE inside {ST_PDOWN, ST_STARTUP})
    else $error("power-down left without start-up wait");
  chk_wait_min: assert property
    ($rose(STATE == ST_STARTUP) |-> (STATE == ST_STARTUP)[*8])
    else $error("start-up wait too short");
  chk_resume_once: assert property (RESUME |=> !RESUME)
    else $error("resume longer than one cycle");
  chk_skip_pair: assert property (HANDLER_SKIP |-> RESUME)
    else $error("handler skip without resume");
  chk_reset_wake: assert property
    (RESET_WAKE |-> !RESUME && !CORE_HALT && $past(CORE_HALT))
    else $error("reset wake malformed");
endmodule
bind sleep_mode_controller sleep_chk i_sleep_chk (
  .MCLK(MCLK), .NRST(NRST), .SLEEP_EXEC(SLEEP_EXEC), .CORE_HALT(CORE_HALT),
  .RESUME(RESUME), .HANDLER_SKIP(HANDLER_SKIP), .RESET_WAKE(RESET_WAKE),
  .IRQ_REQ(IRQ_REQ), .COMP_IRQ(COMP_IRQ), .WDT_RESET(WDT_RESET),
  .EXT_INT_N(EXT_INT_N), .EXT_RESET_N(EXT_RESET_N), .OSC_STOP(OSC_STOP),
  .COMP_POWER_DOWN(COMP_POWER_DOWN), .STATE(STATE));

// [verification/wake_src_model.sv]
// Purpose: watchdog oscillator and external wake pin source
// Assumes: lvl and drop come from the bench on MCLK
// Notes:   second interrupt pin idles high
`timescale 1ns/100ps
module wake_src_model #(
  parameter int HOLD = 60
) (
  // clock
  input  wire logic       MCLK,
  // requests
  input  wire logic       lvl,
  input  wire logic       drop,
  // pins
  output      logic       WDOSC,
  output      logic [1:0] EXT_INT_N
);
  int   held = 0;
  logic low_n = 1'b1;
  initial WDOSC = 1'b0;
  always #1350 WDOSC = ~WDOSC;
  assign EXT_INT_N = {1'b1, low_n};
  // once pulled low, held at least HOLD cycles unless aborted
  always @(posedge MCLK) begin
    if (drop) begin
      low_n <= 1'b1;
      held  <= 0;
    end else if (lvl || (held != 0 && held < HOLD)) begin
      low_n <= 1'b0;
      held  <= held + 1;
    end else begin
      low_n <= 1'b1;
      held  <= 0;
    end
  end
endmodule

// [verification/test_sleep_mode_controller.sv]
// Purpose: self-checking bench of the sleep controller
// Assumes: start-up counts shortened to 16, 32, 64, 128
// Notes:   wake pin and watchdog oscillator come from the partner model
`timescale 1ns/100ps
`include "sleep_map.svh"
module test_sleep_mode_controller;
  import sleep_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0]  b;
  } row_t;
  logic         MCLK = 0, NRST = 0;
  logic [7:0]   awaddr = 0, araddr = 0;
  logic [31:0]  wdata = 0, rdata, d;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, b, inten = 0;
  logic         slp = 0, irq = 0, cirq = 0, wden = 0, wdrst = 0, lvl = 0, drop = 0, xrst = 1;
  logic [3:0]   strb = 4'hf;
  logic         halt, resume, skip, rwake, wdosc, oscs, cpd, got_r, got_s, got_w;
  logic [1:0]   ext_n;
  sleep_state_t state;
  int           n, cyc = 0, n_errors = 0, comparisons = 0;
  row_t rows [4] = '{
    '{`OFS_CORE_CTRL, 32'hffffffff, 32'h3f, `RESP_OKAY},
    '{`OFS_COMP_CTRL, 32'h80, 32'h80, `RESP_OKAY},
    '{`OFS_WAKE_CFG, 32'h03, 32'h03, `RESP_OKAY},
    '{8'h10, 32'h55, 32'h0, `RESP_SLVERR}};
  always #25 MCLK = ~MCLK;
  ////////////////////////////////////////////////////////////////
  sleep_mode_controller #(.STARTUP_CNT0(16'd16), .STARTUP_CNT1(16'd32),
    .STARTUP_CNT2(16'd64), .STARTUP_CNT3(16'd128)) i_sleep_mode_controller (
    .MCLK(MCLK), .NRST(NRST), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SLEEP_EXEC(slp), .CORE_HALT(halt), .RESUME(resume), .HANDLER_SKIP(skip),
    .RESET_WAKE(rwake), .IRQ_REQ(irq), .COMP_IRQ(cirq), .INT_ENABLE(inten),
    .WDT_ENABLE(wden), .WDT_RESET(wdrst), .EXT_INT_N(ext_n), .EXT_RESET_N(xrst),
    .WDOSC(wdosc), .OSC_STOP(oscs), .COMP_POWER_DOWN(cpd), .STATE(state));
  wake_src_model i_wake_src_model (
    .MCLK(MCLK), .lvl(lvl), .drop(drop), .WDOSC(wdosc), .EXT_INT_N(ext_n));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] w, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 0;
    @(posedge MCLK);
    awaddr <= a; wdata <= w; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!tb) begin
      @(negedge MCLK);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
      @(posedge MCLK);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic ta, tr;
    tr = 0;
    @(posedge MCLK);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!tr) begin
      @(negedge MCLK);
      ta = arvalid && arready; tr = rvalid; v = rdata; r = rresp;
      @(posedge MCLK);
      if (ta) arvalid <= 0;
    end
    rready <= 0;
  endtask
  task automatic sleep_now;
    @(posedge MCLK) slp <= 1;
    @(posedge MCLK) slp <= 0;
    @(negedge MCLK);
  endtask
  // cycles until a wake pulse, counted from the last drive edge
  task automatic wt;
    n = 0;
    do begin
      @(negedge MCLK);
      n++;
    end while (!(resume || rwake));
    got_r = resume; got_s = skip; got_w = rwake;
    @(posedge MCLK);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge MCLK);
    NRST <= 1;
    repeat (3) @(posedge MCLK);
    chk("state", state, ST_ACTIVE);
    axr(`OFS_CORE_CTRL, d, b);
    chk("core_rst", d, 32'h0);
    axr(`OFS_SLEEP_STATUS, d, b);
    chk("status", d, 32'h1);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].w, b);
      chk("bresp", b, rows[i].b);
      axr(rows[i].a, d, b);
      chk("rdata", d, rows[i].r);
      chk("rresp", b, rows[i].b);
    end
    axw(`OFS_WAKE_CFG, 32'h0, b);
    axw(`OFS_CORE_CTRL, 32'h0, b);
    sleep_now();
    chk("no_sleep", state, ST_ACTIVE);
    axw(`OFS_CORE_CTRL, 32'h20, b);
    sleep_now();
    chk("idle", state, ST_IDLE);
    chk("halt", halt, 1);
    @(posedge MCLK) cirq <= 1;
    repeat (6) @(posedge MCLK);
    cirq <= 0;
    chk("comp_off", state, ST_IDLE);
    chk("comp_pd", cpd, 1);
    irq <= 1;
    wt();
    irq <= 0;
    chk("idle_lat", n, 2);
    chk("idle_res", {got_r, got_s, got_w}, 3'b100);
    strb <= 0;
    axw(`OFS_CORE_CTRL, 32'h0, b);
    strb <= 4'hf;
    axr(`OFS_CORE_CTRL, d, b);
    chk("kept", d, 32'h20);
    sleep_now();
    @(posedge MCLK) wdrst <= 1;
    wt();
    wdrst <= 0;
    chk("idle_rst", {got_r, got_w}, 2'b01);
    axw(`OFS_CORE_CTRL, 32'h30, b);
    inten <= 2'b01;
    sleep_now();
    chk("pdown", state, ST_PDOWN);
    chk("osc_stop", oscs, 1);
    @(posedge MCLK) irq <= 1;
    repeat (10) @(posedge MCLK);
    irq <= 0;
    chk("pd_edge", state, ST_PDOWN);
    lvl <= 1;
    wt();
    lvl <= 0;
    chk("pd_lat", (n >= 32 && n <= 40), 1);
    chk("pd_res", {got_r, got_s, got_w}, 3'b100);
    repeat (70) @(posedge MCLK);
    sleep_now();
    @(posedge MCLK) lvl <= 1;
    while (state !== ST_STARTUP) @(negedge MCLK);
    @(posedge MCLK) drop <= 1;
    lvl <= 0;
    wt();
    drop <= 0;
    chk("pd_skip", {got_r, got_s}, 2'b11);
    wden <= 1;
    sleep_now();
    @(posedge MCLK) wdrst <= 1;
    wt();
    wdrst <= 0;
    chk("pd_rst", {got_r, got_w}, 2'b01);
    chk("pd_rst_wait", n > 16, 1);
    sleep_now();
    @(posedge MCLK) xrst <= 0;
    wt();
    xrst <= 1;
    chk("pd_x", {got_r, got_w}, 2'b01);
    axw(`OFS_WAKE_CFG, 32'h3, b);
    sleep_now();
    @(posedge MCLK) lvl <= 1;
    wt();
    chk("pd_wd", {n > 185 && n < 245, got_r, got_s}, 3'b110);
    tally_and_finish();
  end
endmodule
